// >>> include/aea_pkg.sv
/*
 * Types shared by the apparent energy accumulator.
 * Assumes aea_regs.svh is on the include path.
 */
`include "aea_regs.svh"

package aea_pkg;

    typedef enum logic [1:0] {
        AEA_LINE_IDLE,
        AEA_LINE_WAIT_ZC,
        AEA_LINE_RUN
    } aea_line_e;

    typedef logic [47:0] aea_acc_t;

endpackage : aea_pkg

// >>> include/aea_regs.svh
/*
 * Register indices, field positions, reset values and timing figures of the
 * apparent energy accumulator. Definitions only.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef AEA_REGS_SVH
`define AEA_REGS_SVH

// Register indices; byte address = 4 * index.
`define AEA_IDX_ENERGY          8'h07
`define AEA_IDX_ENERGY_RC       8'h08
`define AEA_IDX_LINE_ENERGY     8'h09
`define AEA_IDX_MODE            8'h0C
`define AEA_IDX_NOLOAD          8'h0E
`define AEA_IDX_HALF_CYC        8'h12
`define AEA_IDX_GAIN            8'h1F
`define AEA_IDX_DIVISOR         8'h26
`define AEA_IDX_P1_NUM          8'h27
`define AEA_IDX_P1_DEN          8'h28
`define AEA_IDX_P2_NUM          8'h29
`define AEA_IDX_P2_DEN          8'h2A
`define AEA_IDX_IRQ_EN_LOW      8'hD9
`define AEA_IDX_IRQ_EN_MID      8'hDA
`define AEA_IDX_IRQ_EN_HIGH     8'hDB
`define AEA_IDX_IRQ_ST_LOW      8'hDC
`define AEA_IDX_IRQ_ST_MID      8'hDD
`define AEA_IDX_IRQ_ST_HIGH     8'hDE

// Field positions.
`define AEA_BIT_AMP_HOUR        3
`define AEA_BIT_NOLOAD          2
`define AEA_BIT_HALF_FULL       2
`define AEA_BIT_OVERFLOW        5
`define AEA_BIT_CYCLE_END       2
`define AEA_NL_MSB              5
`define AEA_NL_LSB              4

// Reset values.
`define AEA_RST_BYTE            8'h00
`define AEA_RST_WORD            16'h0000
`define AEA_RST_GAIN            12'h000
`define AEA_RST_HALF_CYC        16'hFFFF

// Sample spacing in clocks; pulse low time in ms.
`define AEA_SAMPLE_CYCLES       3'h5
`define AEA_CLK_HZ              100000000
`define AEA_PULSE_LOW_MS        90

`endif

// >>> src/aea_top.sv
/*
 * Apparent energy accumulator with line-cycle energy, no-load detection and pulse.
 * Assumes an APB master on pclk and sample inputs valid on every clock.
 */
`timescale 1ns/1ps
`include "aea_regs.svh"

// Summary of operation
// [R1] Add every sample not below no-load threshold into 48-bit accumulator.
// [R2] Energy register shows upper 24 divided bits.
// [R3] One sample taken every five clocks.
// [R4] Samples added with signed addition.
// [R5] Divide by 8-bit divisor, zero means one.
// [R6] Read-clear register empties on every read.
// [R7] Half-full and overflow events, enables 2, 5.
// [R8] Half-full judged on full 24 bits.
// [R9] Pulse follows gained power or current rms.
// [R10] Pulse output is active low.
// [R11] Line energy summed over half cycles.
// [R12] Half-cycle count is 16-bit unsigned.
// [R13] Cycle end sets flag, enable raises interrupt.
// [R14] Count write clears line energy, restarts.
// [R15] First cycle end after write is valid.
// [R16] Line path shares main path, same weight.
// [R17] Below no-load threshold: no accumulation, flag.
// [R18] No-load interrupt holds until flag cleared.
// [R19] Field 5:4 selects no-load threshold level.
// [R20] Current rms pulse uses same threshold.
// [R21] Mode bit 3 accumulates current rms instead.
// [R22] No offset correction in the power path.
// [R23] Status bit cleared by writing zero.
// [R24] Accumulator wraps, overflow flagged.
module aea_top
    import aea_pkg::*;
#(
    parameter int           PADDR_W          = 12,
    parameter int           SAMPLE_W         = 24,
    parameter logic [23:0]  NL_FULL_SCALE    = 24'h1A36E2,
    parameter int           PULSE_LOW_CYCLES = (`AEA_CLK_HZ / 1000) * `AEA_PULSE_LOW_MS
) (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [PADDR_W-1:0]         paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Measurement inputs
    input  wire logic signed [SAMPLE_W-1:0] apparent_power_in,
    input  wire logic signed [SAMPLE_W-1:0] current_rms_in,
    input  wire logic                       zero_cross,
    // Outputs to the processor and the meter
    output logic                            energy_interrupt,
    output logic                            energy_pulse_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Thresholds and helpers.

    localparam logic [63:0] FS = {40'h0, NL_FULL_SCALE};
    localparam logic [23:0] NL_TH1 = 24'((FS * 64'd3) / 64'd10000);
    localparam logic [23:0] NL_TH2 = 24'((FS * 64'd15) / 64'd100000);
    localparam logic [23:0] NL_TH3 = 24'((FS * 64'd75) / 64'd1000000);

    // A combinational divide keeps every view current, at some area cost.
    function automatic logic [23:0] aea_view(input aea_acc_t acc, input logic [7:0] d);
        logic [47:0] q;
        logic [7:0]  dd;
        // [R5] zero acts as one
        dd = (d == `AEA_RST_BYTE) ? 8'h01 : d;
        q  = acc / {40'h0, dd};
        return q[47:24];
    endfunction : aea_view

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0]  mode_reg;
    logic [7:0]  noload_reg;
    logic [15:0] half_cyc_reg;
    logic [11:0] gain_reg;
    logic [7:0]  divisor_reg;
    logic [15:0] p1_num_reg;
    logic [15:0] p1_den_reg;
    logic [15:0] p2_num_reg;
    logic [15:0] p2_den_reg;
    logic [7:0]  en_low_reg;
    logic [7:0]  en_mid_reg;
    logic [7:0]  en_high_reg;
    logic        st_noload_reg;
    logic        st_half_reg;
    logic        st_ovf_reg;
    logic        st_cyc_reg;

    aea_acc_t    acc_reg;
    aea_acc_t    rc_acc_reg;
    aea_acc_t    line_acc_reg;
    logic [23:0] line_energy_reg;
    logic [15:0] half_cnt_reg;
    aea_line_e   line_state_reg;
    logic [2:0]  div_cnt_reg;
    logic        sample_en;
    logic [23:0] energy_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic [7:0]  idx;
    logic        aligned;
    logic        setup;
    logic        access;
    logic        wr;
    logic        rd;
    logic        hit;
    logic [31:0] rdata;

    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[PADDR_W-1:10] == '0);
    assign setup   = psel && !penable;
    assign access  = psel && penable && pready;
    assign wr      = access && pwrite && !pslverr;
    assign rd      = access && !pwrite && !pslverr;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        if (!aligned) begin
            hit = 1'b0;
        end else if (idx == `AEA_IDX_ENERGY) begin
            // [R2] upper 24 bits
            rdata[23:0] = aea_view(acc_reg, divisor_reg);
        end else if (idx == `AEA_IDX_ENERGY_RC) begin
            rdata[23:0] = aea_view(rc_acc_reg, divisor_reg);
        end else if (idx == `AEA_IDX_LINE_ENERGY) begin
            rdata[23:0] = line_energy_reg;
        end else if (idx == `AEA_IDX_MODE) begin
            rdata[7:0] = mode_reg;
        end else if (idx == `AEA_IDX_NOLOAD) begin
            rdata[7:0] = noload_reg;
        end else if (idx == `AEA_IDX_HALF_CYC) begin
            rdata[15:0] = half_cyc_reg;
        end else if (idx == `AEA_IDX_GAIN) begin
            rdata[11:0] = gain_reg;
        end else if (idx == `AEA_IDX_DIVISOR) begin
            rdata[7:0] = divisor_reg;
        end else if (idx == `AEA_IDX_P1_NUM) begin
            rdata[15:0] = p1_num_reg;
        end else if (idx == `AEA_IDX_P1_DEN) begin
            rdata[15:0] = p1_den_reg;
        end else if (idx == `AEA_IDX_P2_NUM) begin
            rdata[15:0] = p2_num_reg;
        end else if (idx == `AEA_IDX_P2_DEN) begin
            rdata[15:0] = p2_den_reg;
        end else if (idx == `AEA_IDX_IRQ_EN_LOW) begin
            rdata[7:0] = en_low_reg;
        end else if (idx == `AEA_IDX_IRQ_EN_MID) begin
            rdata[7:0] = en_mid_reg;
        end else if (idx == `AEA_IDX_IRQ_EN_HIGH) begin
            rdata[7:0] = en_high_reg;
        end else if (idx == `AEA_IDX_IRQ_ST_LOW) begin
            rdata[`AEA_BIT_NOLOAD] = st_noload_reg;
        end else if (idx == `AEA_IDX_IRQ_ST_MID) begin
            rdata[`AEA_BIT_HALF_FULL] = st_half_reg;
            rdata[`AEA_BIT_OVERFLOW]  = st_ovf_reg;
        end else if (idx == `AEA_IDX_IRQ_ST_HIGH) begin
            rdata[`AEA_BIT_CYCLE_END] = st_cyc_reg;
        end else begin
            hit = 1'b0;
        end
    end

    // Zero wait states: the answer is loaded in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            prdata  <= (setup && !pwrite && hit) ? rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg    <= `AEA_RST_BYTE;
            noload_reg  <= `AEA_RST_BYTE;
            gain_reg    <= `AEA_RST_GAIN;
            divisor_reg <= `AEA_RST_BYTE;
            p1_num_reg  <= `AEA_RST_WORD;
            p1_den_reg  <= `AEA_RST_WORD;
            p2_num_reg  <= `AEA_RST_WORD;
            p2_den_reg  <= `AEA_RST_WORD;
            en_low_reg  <= `AEA_RST_BYTE;
            en_mid_reg  <= `AEA_RST_BYTE;
            en_high_reg <= `AEA_RST_BYTE;
        end else if (wr) begin
            if (idx == `AEA_IDX_MODE) begin
                mode_reg <= pwdata[7:0];
            end else if (idx == `AEA_IDX_NOLOAD) begin
                noload_reg <= pwdata[7:0];
            end else if (idx == `AEA_IDX_GAIN) begin
                gain_reg <= pwdata[11:0];
            end else if (idx == `AEA_IDX_DIVISOR) begin
                divisor_reg <= pwdata[7:0];
            end else if (idx == `AEA_IDX_P1_NUM) begin
                p1_num_reg <= pwdata[15:0];
            end else if (idx == `AEA_IDX_P1_DEN) begin
                p1_den_reg <= pwdata[15:0];
            end else if (idx == `AEA_IDX_P2_NUM) begin
                p2_num_reg <= pwdata[15:0];
            end else if (idx == `AEA_IDX_P2_DEN) begin
                p2_den_reg <= pwdata[15:0];
            end else if (idx == `AEA_IDX_IRQ_EN_LOW) begin
                en_low_reg <= pwdata[7:0];
            end else if (idx == `AEA_IDX_IRQ_EN_MID) begin
                en_mid_reg <= pwdata[7:0];
            end else if (idx == `AEA_IDX_IRQ_EN_HIGH) begin
                en_high_reg <= pwdata[7:0];
            end
        end
    end

    logic wr_half_cyc;
    assign wr_half_cyc = wr && (idx == `AEA_IDX_HALF_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cyc_reg <= `AEA_RST_HALF_CYC;
        end else if (wr_half_cyc) begin
            // [R12] 16-bit count
            half_cyc_reg <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample path.

    // [R3] five-clock sample strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 3'h0;
        end else if (div_cnt_reg == `AEA_SAMPLE_CYCLES - 3'h1) begin
            div_cnt_reg <= 3'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 3'h1;
        end
    end
    assign sample_en = (div_cnt_reg == `AEA_SAMPLE_CYCLES - 3'h1);

    logic signed [SAMPLE_W-1:0]   src;
    logic signed [SAMPLE_W+11:0]  prod;
    logic signed [SAMPLE_W:0]     gained;
    logic        [SAMPLE_W:0]     mag;
    logic        [23:0]           nl_th;
    logic                         below;
    logic signed [48:0]           sample_ext;

    // [R21] current rms replaces apparent power; [R22] no offset term added
    assign src  = mode_reg[`AEA_BIT_AMP_HOUR] ? current_rms_in : apparent_power_in;
    assign prod = src * $signed(gain_reg);
    // [R9] gain-corrected signal feeds energy and pulse alike
    assign gained = (SAMPLE_W+1)'(src) + (SAMPLE_W+1)'(prod >>> 12);
    assign mag    = gained[SAMPLE_W] ? (SAMPLE_W+1)'(-gained) : gained;

    // [R19] threshold select
    always_comb begin
        case (noload_reg[`AEA_NL_MSB:`AEA_NL_LSB])
            2'b01:   nl_th = NL_TH1;
            2'b10:   nl_th = NL_TH2;
            2'b11:   nl_th = NL_TH3;
            default: nl_th = 24'h000000;
        endcase
    end
    // [R20] the same compare applies in current rms mode
    assign below      = (nl_th != 24'h000000) && (mag < (SAMPLE_W+1)'(nl_th));
    assign sample_ext = 49'(gained);

    logic add_en;
    // [R17] no accumulation below threshold
    assign add_en = sample_en && !below;

    aea_acc_t acc_sum;
    // [R4] signed addition
    assign acc_sum = acc_reg + sample_ext[47:0];

    // [R1] [R24] main 48-bit accumulator, wraps freely
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= '0;
        end else if (add_en) begin
            acc_reg <= acc_sum;
        end
    end

    // [R6] a read empties it; a coincident sample starts the new total.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_acc_reg <= '0;
        end else if (rd && (idx == `AEA_IDX_ENERGY_RC)) begin
            rc_acc_reg <= add_en ? sample_ext[47:0] : '0;
        end else if (add_en) begin
            rc_acc_reg <= rc_acc_reg + sample_ext[47:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line-cycle accumulation.

    logic cycle_done;
    logic [15:0] target;
    // A count of zero acts as one.
    assign target     = (half_cyc_reg == `AEA_RST_WORD) ? 16'h0001 : half_cyc_reg;
    assign cycle_done = (line_state_reg == AEA_LINE_RUN) && zero_cross
                        && (half_cnt_reg + 16'h0001 == target);

    // [R11] always running; [R14] count write clears and re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_state_reg  <= AEA_LINE_WAIT_ZC;
            line_acc_reg    <= '0;
            half_cnt_reg    <= 16'h0000;
            line_energy_reg <= 24'h000000;
        end else if (wr_half_cyc) begin
            line_state_reg  <= AEA_LINE_WAIT_ZC;
            line_acc_reg    <= '0;
            half_cnt_reg    <= 16'h0000;
            line_energy_reg <= 24'h000000;
        end else begin
            case (line_state_reg)
                AEA_LINE_WAIT_ZC: begin
                    if (zero_cross) begin
                        line_state_reg <= AEA_LINE_RUN;
                    end
                end
                AEA_LINE_RUN: begin
                    if (cycle_done) begin
                        // [R15] full period since the arming crossing
                        // [R16] same divided view as the main register
                        line_energy_reg <= aea_view(add_en ? line_acc_reg
                                            + sample_ext[47:0] : line_acc_reg,
                                            divisor_reg);
                        line_acc_reg    <= '0;
                        half_cnt_reg    <= 16'h0000;
                    end else begin
                        if (add_en) begin
                            line_acc_reg <= line_acc_reg + sample_ext[47:0];
                        end
                        if (zero_cross) begin
                            half_cnt_reg <= half_cnt_reg + 16'h0001;
                        end
                    end
                end
                default: begin
                    line_state_reg <= AEA_LINE_WAIT_ZC;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and status.

    logic [23:0] energy_now;
    logic        half_evt;
    logic        ovf_evt;
    assign energy_now = aea_view(acc_reg, divisor_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_prev_reg <= 24'h000000;
        end else begin
            energy_prev_reg <= energy_now;
        end
    end

    // [R8] half full on bit 23 of the unsigned 24-bit view
    assign half_evt = energy_now[23] && !energy_prev_reg[23];
    // [R24] a positive sample wrapping the total
    assign ovf_evt  = add_en && !sample_ext[48] && acc_reg[47] && !acc_sum[47];

    logic clr_low;
    logic clr_mid;
    logic clr_high;
    assign clr_low  = wr && (idx == `AEA_IDX_IRQ_ST_LOW);
    assign clr_mid  = wr && (idx == `AEA_IDX_IRQ_ST_MID);
    assign clr_high = wr && (idx == `AEA_IDX_IRQ_ST_HIGH);

    // [R23] writing zero clears a flag; a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_noload_reg <= 1'b0;
            st_half_reg   <= 1'b0;
            st_ovf_reg    <= 1'b0;
            st_cyc_reg    <= 1'b0;
        end else begin
            // [R17] no-load flag
            if (sample_en && below) begin
                st_noload_reg <= 1'b1;
            end else if (clr_low && !pwdata[`AEA_BIT_NOLOAD]) begin
                st_noload_reg <= 1'b0;
            end
            if (half_evt) begin
                st_half_reg <= 1'b1;
            end else if (clr_mid && !pwdata[`AEA_BIT_HALF_FULL]) begin
                st_half_reg <= 1'b0;
            end
            if (ovf_evt) begin
                st_ovf_reg <= 1'b1;
            end else if (clr_mid && !pwdata[`AEA_BIT_OVERFLOW]) begin
                st_ovf_reg <= 1'b0;
            end
            // [R13] cycle end flag
            if (cycle_done) begin
                st_cyc_reg <= 1'b1;
            end else if (clr_high && !pwdata[`AEA_BIT_CYCLE_END]) begin
                st_cyc_reg <= 1'b0;
            end
        end
    end

    // [R7] [R13] [R18] gated interrupt level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_interrupt <= 1'b0;
        end else begin
            energy_interrupt <= (st_noload_reg && en_low_reg[`AEA_BIT_NOLOAD])
                             || (st_half_reg && en_mid_reg[`AEA_BIT_HALF_FULL])
                             || (st_ovf_reg && en_mid_reg[`AEA_BIT_OVERFLOW])
                             || (st_cyc_reg && en_high_reg[`AEA_BIT_CYCLE_END]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Energy-to-pulse conversion.

    logic [15:0] num_eff;
    logic [15:0] den_eff;
    logic [16:0] phase_reg;
    logic [16:0] phase_sum;
    logic        lsb_tick;
    logic        fire;
    logic [31:0] low_cnt_reg;

    // Zero acts as one; a ratio above one clamps to one.
    assign den_eff   = (p1_den_reg == `AEA_RST_WORD) ? 16'h0001 : p1_den_reg;
    assign num_eff   = (p1_num_reg == `AEA_RST_WORD) ? 16'h0001
                     : ((p1_num_reg > den_eff) ? den_eff : p1_num_reg);
    // One LSB step per clock at most is counted.
    assign lsb_tick  = (energy_now != energy_prev_reg);
    assign phase_sum = phase_reg + {1'b0, num_eff};
    assign fire      = lsb_tick && (phase_sum >= {1'b0, den_eff});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= 17'h00000;
        end else if (lsb_tick) begin
            phase_reg <= fire ? phase_sum - {1'b0, den_eff} : phase_sum;
        end
    end

    // [R10] active-low pulse, retriggered by each fire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_reg    <= 32'h0000_0000;
            energy_pulse_n <= 1'b1;
        end else if (fire) begin
            low_cnt_reg    <= 32'(PULSE_LOW_CYCLES - 1);
            energy_pulse_n <= 1'b0;
        end else if (low_cnt_reg != 32'h0000_0000) begin
            low_cnt_reg    <= low_cnt_reg - 32'h0000_0001;
        end else begin
            energy_pulse_n <= 1'b1;
        end
    end

endmodule : aea_top

// >>> tb/aea_front.sv
/* Metering front end model: sample streams and zero-crossing pulses.
 * Assumes the bench sets the level and which stream carries it. */
`timescale 1ns/1ps
module aea_front #(
    parameter int HALF = 50
) (
    // Control
    input  wire logic               pclk,
    input  wire logic               run,
    input  wire logic               amp,
    input  wire logic signed [23:0] level,
    // Streams
    output logic signed [23:0]      power,
    output logic signed [23:0]      irms,
    output logic                    zc
);
    int cnt;
    // The idle stream is zero so a wrong source select shows in the totals.
    assign power = amp ? 24'sh000000 : level;
    assign irms  = amp ? level : 24'sh000000;
    always_ff @(posedge pclk) begin
        cnt <= (run && cnt < HALF - 1) ? cnt + 1 : 0;
        zc  <= run && cnt == HALF - 1;
    end
endmodule : aea_front

// >>> tb/aea_sva.sv
/* Port checker for the apparent energy accumulator.
 * Assumes a 12-bit byte address and a sim pulse low time of at least 8 clocks. */
`timescale 1ns/1ps
module aea_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus and outputs
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        energy_interrupt,
    input wire logic        energy_pulse_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_in_access: assert property (psel && penable |-> pready) else $error("no ready");
    a_ready_only_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("rdata not 0");
    a_err_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("no error on unaligned");
    a_err_out_range: assert property (pready && paddr[11:10] != 2'h0 |-> pslverr)
        else $error("no error out of range");
    a_energy_narrow: assert property (
        pready && !pwrite && paddr == 12'h01C |-> !pslverr && prdata[31:24] == 8'h00)
        else $error("energy read wide");
    a_irq_clear_write: assert property (
        $fell(energy_interrupt) |-> $past(pready && pwrite, 2)) else $error("irq fell alone");
    a_pulse_low_hold: assert property (
        $fell(energy_pulse_n) |-> !energy_pulse_n [*8]) else $error("pulse too short");
endmodule : aea_sva

bind aea_top aea_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .energy_interrupt(energy_interrupt), .energy_pulse_n(energy_pulse_n));

// >>> tb/testbench.sv
/* Self-checking bench for the apparent energy accumulator.
 * Assumes the checker binds itself and the front model feeds the samples. */
`timescale 1ns/1ps
`include "aea_regs.svh"
module testbench;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic               pwrite = 1'b0, run = 1'b0, amp = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, rd, base;
    logic               pready, pslverr, irq, pulse_n, zc, err;
    logic signed [23:0] level = 24'sh000000, pw, ir;
    int                 failures = 0, n_checks = 0, cycles = 0;

    aea_top #(.PULSE_LOW_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .apparent_power_in(pw), .current_rms_in(ir),
        .zero_cross(zc), .energy_interrupt(irq), .energy_pulse_n(pulse_n));
    aea_front u_front (.pclk(pclk), .run(run), .amp(amp), .level(level), .power(pw),
        .irms(ir), .zc(zc));

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            failures = failures + 1;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction : ad
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Idle edge first so a release is never overwritten.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rc(ad(`AEA_IDX_HALF_CYC), 32'h0000FFFF);
        apb(1'b1, ad(`AEA_IDX_DIVISOR), 32'h000001FF);
        rc(ad(`AEA_IDX_DIVISOR), 32'h000000FF);
        apb(1'b0, 12'h01D, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h800, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("regs test done");
    endtask : t_regs
    // 200 clocks: 40 samples of 2^22, ten LSBs.
    task automatic t_energy(input logic m, input logic [7:0] dv, input logic [31:0] exp);
        apb(1'b1, ad(`AEA_IDX_MODE), {28'h0, m, 3'h0});
        apb(1'b1, ad(`AEA_IDX_DIVISOR), {24'h0, dv});
        amp <= m;
        apb(1'b0, ad(`AEA_IDX_ENERGY_RC), 32'h0);
        apb(1'b0, ad(`AEA_IDX_ENERGY), 32'h0);
        base = rd;
        level <= 24'sh400000;
        repeat (200) @(posedge pclk);
        level <= 24'sh000000;
        rc(ad(`AEA_IDX_ENERGY), base + exp);
        rc(ad(`AEA_IDX_ENERGY_RC), exp);
        rc(ad(`AEA_IDX_ENERGY_RC), 32'h0);
        $display("energy test done");
    endtask : t_energy
    task automatic t_noload();
        level <= 24'sh0000C0;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ad(`AEA_IDX_NOLOAD), m << 4);
            apb(1'b1, ad(`AEA_IDX_IRQ_EN_LOW), {29'h0, m[1], 2'h0});
            apb(1'b1, ad(`AEA_IDX_IRQ_ST_LOW), 32'h0);
            repeat (20) @(posedge pclk);
            rc(ad(`AEA_IDX_IRQ_ST_LOW), (m == 1 || m == 2) ? 32'h4 : 32'h0);
            chk({31'h0, irq}, (m == 2) ? 32'h1 : 32'h0);
        end
        apb(1'b1, ad(`AEA_IDX_NOLOAD), 32'h0);
        $display("no-load test done");
    endtask : t_noload
    // A 100-clock period: 20 samples of 2^20, one LSB.
    task automatic t_line();
        apb(1'b1, ad(`AEA_IDX_IRQ_EN_HIGH), 32'h4);
        level <= 24'sh100000;
        apb(1'b1, ad(`AEA_IDX_HALF_CYC), 32'h2);
        rc(ad(`AEA_IDX_LINE_ENERGY), 32'h0);
        run <= 1'b1;
        repeat (400) @(posedge pclk);
        rc(ad(`AEA_IDX_LINE_ENERGY), 32'h1);
        rc(ad(`AEA_IDX_IRQ_ST_HIGH), 32'h4);
        chk({31'h0, irq}, 32'h1);
        run <= 1'b0;
        level <= 24'sh000000;
        apb(1'b1, ad(`AEA_IDX_IRQ_ST_HIGH), 32'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        $display("line test done");
    endtask : t_line
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_energy(1'b0, 8'h02, 32'h5);
        t_energy(1'b1, 8'h00, 32'hA);
        t_energy(1'b0, 8'h00, 32'hA);
        t_noload();
        t_line();
        end_sim();
    end
endmodule : testbench
